// ===== dv/ppp_port_tb.sv
`timescale 1ns/100ps
module ppp_port_tb;
	import ppp_pkg::*;
	logic        clk_sys = 1'b0;
	logic        rst_n, keep_fuse, reset_pin_n, hv_detect, load_strobe, action_sel_0;
	logic        action_sel_1, page_latch, write_strobe_n, output_drive_n, drv_en;
	logic        data_oe, ready_not_busy, prog_active, flash_we, erase_flash;
	logic        erase_eeprom, clear_locks, ee_page_we;
	logic [7:0]  rd_byte, bus, data_drv, data_out, cmd_out;
	logic [7:0]  float_q = 8'hA5;
	logic [12:0] flash_addr;
	logic [15:0] flash_wdata;
	logic [28:0] exp_q[$];
	int          fails = 0, num_checks = 0, cyc = 0;
	int          n_ef = 0, n_ee = 0, n_cl = 0, n_we = 0, t_ef = 0, t_cl = 0, n_pe = 0;
	bit          ok;

	always #4 clk_sys = ~clk_sys;
	// an undriven bus toggles so it can never pass for the expected byte
	always @(posedge clk_sys) float_q <= ~float_q;
	assign bus = data_oe ? data_out : (drv_en ? data_drv : float_q);

	ppp_prog_model i_prog (
		.clk_sys, .ready_not_busy, .reset_pin_n, .hv_detect, .load_strobe, .action_sel_0,
		.action_sel_1, .page_latch, .write_strobe_n, .output_drive_n, .data_drv, .drv_en
	);
	ppp_port i_dut (
		.clk_sys, .rst_n, .reset_pin_n, .hv_detect, .load_strobe, .action_sel_0, .action_sel_1,
		.page_latch, .write_strobe_n, .output_drive_n, .data_in(bus),
		.eeprom_keep_fuse(keep_fuse), .flash_rd_data(rd_byte), .data_out, .data_oe,
		.ready_not_busy, .prog_active, .flash_we, .flash_addr, .flash_wdata, .erase_flash,
		.erase_eeprom, .clear_locks, .ee_page_we, .cmd_out
	);
	////////////////////////////////////////////////////////////////
	task automatic end_sim();
		if (fails == 0 && num_checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	task automatic chk_bit(input string nm, input logic e, input logic g);
		num_checks++;
		if (g !== e) begin
			fails++;
			$display("BAD %s expected %b seen %b", nm, e, g);
		end
	endtask
	task automatic chk_val(input string nm, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			fails++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask
	always @(posedge clk_sys) begin
		cyc++;
		if (erase_flash === 1'b1) begin
			n_ef++;
			t_ef = cyc;
		end
		if (erase_eeprom === 1'b1) n_ee++;
		if (ee_page_we === 1'b1) n_pe++;
		if (clear_locks === 1'b1) begin
			n_cl++;
			t_cl = cyc;
		end
		if (flash_we === 1'b1) begin
			n_we++;
			if (exp_q.size() > 0) begin
				chk_val("flash_word", exp_q[0], {flash_addr, flash_wdata});
				exp_q.delete(0);
			end
		end
	end
	////////////////////////////////////////////////////////////////
	task automatic t_reset();
		chk_bit("ready_not_busy", 1'b1, ready_not_busy);
		chk_bit("prog_active", 1'b0, prog_active);
		chk_bit("data_oe", 1'b0, data_oe);
	endtask
	task automatic t_entry();
		i_prog.enter(1'b1);
		chk_bit("prog_active", 1'b0, prog_active);
		i_prog.enter(1'b0);
		chk_bit("prog_active", 1'b1, prog_active);
	endtask
	task automatic t_cmds();
		logic [7:0] cmds[10];
		logic [1:0] acts[3];
		cmds = '{CMD_ERASE, CMD_WR_FUSE, CMD_WR_LOCK, CMD_WR_FLASH, CMD_WR_EE,
			CMD_RD_SIG, CMD_RD_FUSE, CMD_RD_FLASH, CMD_RD_EE, CMD_NOP};
		acts = '{ACT_IDLE, ACT_ADDR, ACT_DATA};
		foreach (cmds[i]) begin
			i_prog.load(ACT_CMD, 1'b0, cmds[i]);
			chk_val("cmd_out", cmds[i], cmd_out);
		end
		foreach (acts[i]) begin
			i_prog.load(acts[i], 1'b0, 8'h80);
			chk_val("cmd_out", CMD_NOP, cmd_out);
		end
	endtask
	task automatic t_erase(input logic fuse, input int n_exp);
		keep_fuse = fuse;
		n_ef = 0;
		n_ee = 0;
		n_cl = 0;
		i_prog.load(ACT_CMD, 1'b0, CMD_ERASE);
		i_prog.wr();
		chk_bit("ready_not_busy", 1'b0, ready_not_busy);
		i_prog.load(ACT_CMD, 1'b0, CMD_WR_FLASH);
		chk_val("cmd_out", CMD_ERASE, cmd_out);
		i_prog.wait_ready(ok);
		chk_bit("erase_done", 1'b1, ok);
		chk_val("erase_flash", 1, n_ef);
		chk_val("erase_eeprom", n_exp, n_ee);
		chk_val("clear_locks", 1, n_cl);
		chk_bit("locks_last", 1'b1, t_cl > t_ef);
	endtask
	task automatic t_page();
		logic [7:0] lo, hi;
		i_prog.load(ACT_CMD, 1'b0, CMD_WR_FLASH);
		i_prog.load(ACT_ADDR, 1'b1, 8'h03);
		// one word past the buffer depth must be dropped
		for (int i = 0; i < FIFO_DEPTH + 1; i++) begin
			lo = 8'h10 + 8'(i);
			hi = 8'hA0 + 8'(i);
			i_prog.load(ACT_ADDR, 1'b0, {2'b01, 6'(i)});
			i_prog.load(ACT_DATA, 1'b0, lo);
			i_prog.load(ACT_DATA, 1'b1, hi);
			i_prog.latch();
			if (i < FIFO_DEPTH) exp_q.push_back({5'h03, 2'b01, 6'(i), hi, lo});
		end
		n_we = 0;
		i_prog.wr();
		chk_bit("ready_not_busy", 1'b0, ready_not_busy);
		i_prog.wait_ready(ok);
		chk_bit("prog_done", 1'b1, ok);
		chk_val("words_written", FIFO_DEPTH, n_we);
		chk_val("cmd_out", CMD_WR_FLASH, cmd_out);
		i_prog.load(ACT_ADDR, 1'b0, 8'h85);
		i_prog.load(ACT_DATA, 1'b0, 8'h5C);
		i_prog.load(ACT_DATA, 1'b1, 8'h3E);
		i_prog.latch();
		exp_q.push_back({5'h03, 2'b10, 6'h05, 8'h3E, 8'h5C});
		i_prog.wr();
		i_prog.wait_ready(ok);
		chk_val("words_written", FIFO_DEPTH + 1, n_we);
		i_prog.load(ACT_CMD, 1'b0, CMD_WR_EE);
		i_prog.load(ACT_ADDR, 1'b0, 8'h02);
		i_prog.load(ACT_DATA, 1'b0, 8'h77);
		i_prog.latch();
		n_pe = 0;
		i_prog.wr();
		i_prog.wait_ready(ok);
		chk_val("ee_page_we", 1, n_pe);
		chk_val("words_written", FIFO_DEPTH + 1, n_we);
		i_prog.latch();
		i_prog.load(ACT_CMD, 1'b0, CMD_NOP);
		i_prog.wr();
		chk_bit("ready_not_busy", 1'b1, ready_not_busy);
		chk_val("words_written", FIFO_DEPTH + 1, n_we);
		chk_val("ee_page_we", 1, n_pe);
	endtask
	task automatic t_read();
		// high byte is mixed with the loaded data high byte, so clear it
		i_prog.load(ACT_DATA, 1'b1, 8'h00);
		i_prog.load(ACT_CMD, 1'b0, CMD_RD_FLASH);
		rd_byte = 8'hC3;
		i_prog.rd(1'b0, 1'b0);
		chk_bit("data_oe", 1'b1, data_oe);
		chk_val("data_low", 8'hC3, bus);
		rd_byte = 8'h3C;
		i_prog.rd(1'b1, 1'b0);
		chk_val("data_high", 8'h3C, bus);
		i_prog.rd(1'b0, 1'b1);
		chk_bit("data_oe", 1'b0, data_oe);
		// fuse byte written with byte_sel_ext high reads back on that select
		i_prog.load(ACT_CMD, 1'b0, CMD_WR_FUSE);
		i_prog.load(ACT_DATA, 1'b0, 8'h96);
		i_prog.load(ACT_IDLE, 1'b0, 8'h00);
		i_prog.wr();
		i_prog.load(ACT_CMD, 1'b0, CMD_RD_FUSE);
		i_prog.rd(1'b0, 1'b0);
		chk_val("fuse_ext", 8'h96, bus);
		i_prog.rd(1'b0, 1'b1);
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		rst_n = 1'b0;
		keep_fuse = 1'b1;
		rd_byte = 8'h00;
		repeat (20) @(posedge clk_sys);
		#1;
		rst_n = 1'b1;
		i_prog.tick(2);
		t_reset();
		t_entry();
		t_cmds();
		t_erase(1'b1, 1);
		t_erase(1'b0, 0);
		t_page();
		t_read();
		end_sim();
	end
	initial begin
		#240000;
		fails++;
		end_sim();
	end
endmodule

// ===== dv/ppp_prog_model.sv
`timescale 1ns/100ps
module ppp_prog_model
	import ppp_pkg::*;
(
	input  wire logic       clk_sys,        // clock
	input  wire logic       ready_not_busy, // device ready
	output logic            reset_pin_n,    // reset pin
	output logic            hv_detect,      // programming level
	output logic            load_strobe,    // action strobe
	output logic            action_sel_0,   // action bit 0
	output logic            action_sel_1,   // action bit 1
	output logic            page_latch,     // latch / byte select
	output logic            write_strobe_n, // write pulse
	output logic            output_drive_n, // read enable
	output logic      [7:0] data_drv,       // bus value
	output logic            drv_en          // driving the bus
);
	// let go of the bus whenever the device may drive it
	assign drv_en = output_drive_n;
	initial begin
		reset_pin_n = 1'b1;
		hv_detect = 1'b0;
		load_strobe = 1'b0;
		{action_sel_1, action_sel_0} = ACT_IDLE;
		page_latch = 1'b0;
		write_strobe_n = 1'b1;
		output_drive_n = 1'b1;
		data_drv = 8'h00;
	end
	////////////////////////////////////////////////////////////////
	// pins pass two flops and an edge detector, so hold each level 4 cycles
	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask
	task automatic pulse_ls();
		load_strobe = 1'b1;
		tick(4);
		load_strobe = 1'b0;
		tick(4);
	endtask
	task automatic enter(input bit glitch);
		reset_pin_n = 1'b0;
		hv_detect = 1'b0;
		tick(4);
		repeat (6) pulse_ls();
		{page_latch, action_sel_1, action_sel_0, write_strobe_n} = 4'h0;
		tick(ENTRY_SETTLE_CYC + 4);
		reset_pin_n = 1'b1;
		hv_detect = 1'b1;
		tick(5);
		action_sel_0 = glitch; // deliberate disturbance inside the settle window
		tick(ENTRY_SETTLE_CYC + 8);
		write_strobe_n = 1'b1;
		{action_sel_1, action_sel_0} = ACT_IDLE;
		if (!glitch) tick(6250);
	endtask
	task automatic load(input logic [1:0] act, input logic hi, input logic [7:0] val);
		{action_sel_1, action_sel_0} = act;
		page_latch = hi;
		data_drv = val;
		tick(4);
		pulse_ls();
	endtask
	task automatic latch();
		page_latch = 1'b0;
		tick(4);
		page_latch = 1'b1;
		tick(4);
		page_latch = 1'b0;
		tick(4);
	endtask
	task automatic wr();
		write_strobe_n = 1'b0;
		tick(4);
		write_strobe_n = 1'b1;
		tick(4);
	endtask
	task automatic rd(input logic hi, input logic en_n);
		page_latch = hi;
		output_drive_n = en_n;
		tick(6);
	endtask
	task automatic wait_ready(output bit ok);
		for (int k = 0; k < 300 && ready_not_busy !== 1'b1; k++) tick(1);
		ok = (ready_not_busy === 1'b1);
	endtask
endmodule

// ===== pkg/ppp_pkg.sv
package ppp_pkg;
	localparam int CLK_MHZ         = 125;
	// entry timing
	localparam int ENTRY_SETTLE_NS = 100;
	localparam int ENTRY_SETTLE_CYC =
		(ENTRY_SETTLE_NS * CLK_MHZ + 999) / 1000;
	localparam int STROBE_MIN      = 6;
	// internal operation lengths, in cycles
	localparam int ERASE_CYC       = 64;
	localparam int PROG_CYC        = 32;
	// page geometry
	localparam int PAGE_WORDS      = 64;
	localparam int WORD_BITS       = 6;
	localparam int PAGE_LSB        = 6;
	localparam int PAGE_MSB        = 12;
	localparam int FIFO_DEPTH      = 8;
	// action codes
	localparam logic [1:0] ACT_ADDR = 2'h0;
	localparam logic [1:0] ACT_DATA = 2'h1;
	localparam logic [1:0] ACT_CMD  = 2'h2;
	localparam logic [1:0] ACT_IDLE = 2'h3;
	// command bytes
	localparam logic [7:0] CMD_NOP      = 8'h00;
	localparam logic [7:0] CMD_ERASE    = 8'h80;
	localparam logic [7:0] CMD_WR_FUSE  = 8'h40;
	localparam logic [7:0] CMD_WR_LOCK  = 8'h20;
	localparam logic [7:0] CMD_WR_FLASH = 8'h10;
	localparam logic [7:0] CMD_WR_EE    = 8'h11;
	localparam logic [7:0] CMD_RD_SIG   = 8'h08;
	localparam logic [7:0] CMD_RD_FUSE  = 8'h04;
	localparam logic [7:0] CMD_RD_FLASH = 8'h02;
	localparam logic [7:0] CMD_RD_EE    = 8'h03;
	localparam logic [7:0] SIG_DEFAULT  = 8'h5A; // arbitrary value
	typedef enum logic [1:0] {
		PPP_OFF   = 2'b00,
		PPP_ARMED = 2'b01,
		PPP_SETTLE= 2'b11,
		PPP_ON    = 2'b10
	} ppp_mode_t;
	typedef enum logic [1:0] {
		PPP_IDLE  = 2'b00,
		PPP_ERASE = 2'b01,
		PPP_PROG  = 2'b11,
		PPP_DONE  = 2'b10
	} ppp_op_t;
endpackage

// ===== pkg/ppp_word_if.sv
`timescale 1ns/100ps
interface ppp_word_if;
	logic        valid;
	logic        ready;
	logic [21:0] word;  // {index[5:0], hi, lo}
	modport src (output valid, output word, input ready);
	modport dst (input valid, input word, output ready);
endinterface

// ===== rtl/ppp_fifo.sv
`timescale 1ns/100ps
module ppp_fifo #(
	parameter int WIDTH = 22,
	parameter int DEPTH = 8
) (
	input  wire logic clk_sys,   // system clock
	input  wire logic rst_n,     // async reset
	ppp_word_if.dst   wr,        // fill side
	ppp_word_if.src   rd         // drain side
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0]    wp_q;
	logic [AW-1:0]    rp_q;
	logic [AW:0]      cnt_q;
	wire              push = wr.valid && wr.ready;
	wire              pop  = rd.valid && rd.ready;

	assign wr.ready = cnt_q != (AW+1)'(DEPTH);
	assign rd.valid = cnt_q != '0;
	assign rd.word  = mem_q[rp_q];

	always_ff @(posedge clk_sys) begin
		if (push) mem_q[wp_q] <= wr.word;
	end
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			wp_q  <= '0;
			rp_q  <= '0;
			cnt_q <= '0;
		end else begin
			if (push) wp_q <= wp_q + 1'b1;
			if (pop) rp_q <= rp_q + 1'b1;
			cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
	fifo_bound_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		cnt_q <= (AW+1)'(DEPTH)) else $error("fifo count overflow");
endmodule

// ===== rtl/ppp_port.sv
`timescale 1ns/100ps
module ppp_port
	import ppp_pkg::*;
(
	input  wire logic       clk_sys,          // system clock
	input  wire logic       rst_n,            // async reset, active low
	input  wire logic       reset_pin_n,      // device reset pin, low = reset
	input  wire logic       hv_detect,        // reset pin at programming level
	input  wire logic       load_strobe,      // action strobe
	input  wire logic       action_sel_0,     // action bit 0
	input  wire logic       action_sel_1,     // action bit 1 / byte_sel_ext
	input  wire logic       page_latch,       // page latch / byte_sel_hi
	input  wire logic       write_strobe_n,   // write pulse, active low
	input  wire logic       output_drive_n,   // output enable, active low
	input  wire logic [7:0] data_in,          // data bus input
	input  wire logic       eeprom_keep_fuse, // programmed (0) keeps eeprom
	input  wire logic [7:0] flash_rd_data,    // array byte read
	output logic      [7:0] data_out,         // data bus output
	output logic            data_oe,          // data bus drive enable
	output logic            ready_not_busy,   // 1 = ready
	output logic            prog_active,      // programming mode entered
	output logic            flash_we,         // array word write pulse
	output logic      [12:0] flash_addr,      // array word address
	output logic      [15:0] flash_wdata,     // array write word
	output logic            erase_flash,      // erase program memory pulse
	output logic            erase_eeprom,     // erase eeprom pulse
	output logic            clear_locks,      // lock release pulse
	output logic            ee_page_we,       // eeprom page write pulse
	output logic      [7:0] cmd_out           // loaded command
);
	////////////////////////////////////////////////////////////////////////
	logic [13:0] pin_s;
	ppp_sync #(.W(14)) u_sync (
		.clk_sys (clk_sys),
		.rst_n   (rst_n),
		.d       ({reset_pin_n, hv_detect, load_strobe, action_sel_0,
			action_sel_1, page_latch, write_strobe_n, output_drive_n,
			data_in[5:0]}),
		.q       (pin_s)
	);
	logic [1:0] dhi_s1_q, dhi_q;
	wire rst_s  = pin_s[13];
	wire hv_s   = pin_s[12];
	wire ls_s   = pin_s[11];
	wire a0_s   = pin_s[10];
	wire a1_s   = pin_s[9];
	wire pl_s   = pin_s[8];
	wire wr_s   = pin_s[7];
	wire oe_s   = pin_s[6];
	wire [7:0] din_s = {dhi_q, pin_s[5:0]};
	logic ls_q, pl_q, wr_q;
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			dhi_s1_q <= '0;
			dhi_q    <= '0;
			ls_q     <= 1'b0;
			pl_q     <= 1'b0;
			wr_q     <= 1'b0; // synchroniser resets low too, so no false fall
		end else begin
			dhi_s1_q <= data_in[7:6];
			dhi_q    <= dhi_s1_q;
			ls_q     <= ls_s;
			pl_q     <= pl_s;
			wr_q     <= wr_s;
		end
	end
	wire ls_rise = ls_s && !ls_q;
	wire pl_rise = pl_s && !pl_q;
	wire wr_fall = !wr_s && wr_q;
	wire [3:0] pattern = {pl_s, a1_s, a0_s, wr_s};

	////////////////////////////////////////////////////////////////////////
	// entry sequence
	ppp_mode_t  mode_q, mode_d;
	logic [2:0] nstrobe_q;
	logic [7:0] settle_q;
	always_comb begin
		mode_d = mode_q;
		unique case (mode_q)
			PPP_OFF:    if (rst_s) mode_d = PPP_OFF;
				else if (nstrobe_q >= 3'(STROBE_MIN) && pattern == 4'h0)
					mode_d = PPP_ARMED;
			PPP_ARMED:  if (pattern != 4'h0) mode_d = PPP_OFF;
				else if (hv_s) mode_d = PPP_SETTLE;
			PPP_SETTLE: if (pattern != 4'h0 || !hv_s) mode_d = PPP_OFF;
				else if (settle_q == 8'(ENTRY_SETTLE_CYC)) mode_d = PPP_ON;
			PPP_ON:     if (!hv_s) mode_d = PPP_OFF;
		endcase
	end
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			mode_q    <= PPP_OFF;
			nstrobe_q <= '0;
			settle_q  <= '0;
		end else begin
			mode_q <= mode_d;
			// reset-phase strobe count gates entry
			if (rst_s) nstrobe_q <= '0;
			else if (mode_q == PPP_OFF && !hv_s && ls_rise && nstrobe_q != 3'h7)
				nstrobe_q <= nstrobe_q + 1'b1;
			settle_q <= (mode_q == PPP_SETTLE) ? settle_q + 1'b1 : '0;
		end
	end
	wire on = mode_q == PPP_ON;

	////////////////////////////////////////////////////////////////////////
	// command, address and data loads
	logic [7:0] cmd_q, alo_q, ahi_q, dlo_q, dhi_q2, dext_q;
	ppp_op_t    op_q;
	logic [7:0] opcnt_q;
	logic       wr_en_q;
	wire        busy    = op_q != PPP_IDLE;
	wire        load_ok = on && ls_rise && !busy;
	wire [1:0]  act     = {a1_s, a0_s};
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			cmd_q  <= CMD_NOP;
			alo_q  <= '0;
			ahi_q  <= '0;
			dlo_q  <= '0;
			dhi_q2 <= '0;
			wr_en_q <= 1'b0;
		end else if (load_ok) begin
			// command and address persist until reloaded
			unique case (act)
				ACT_ADDR: if (pl_s) ahi_q <= din_s; else alo_q <= din_s;
				ACT_DATA: if (pl_s) dhi_q2 <= din_s;
					else dlo_q <= din_s;
				ACT_CMD: begin
					cmd_q   <= din_s;
					wr_en_q <= din_s != CMD_NOP;
				end
				ACT_IDLE: ;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// page buffer via fifo, drained on program start
	ppp_word_if w_in ();
	ppp_word_if w_out ();
	logic drain_q;
	wire [5:0] word_idx = alo_q[WORD_BITS-1:0];
	wire [6:0] page_idx = {ahi_q[4:0], alo_q[7:6]};
	wire is_wflash = cmd_q == CMD_WR_FLASH || cmd_q == CMD_WR_EE;
	// the pin doubles as byte_sel_hi: a high level that framed a load is a
	// select, so a word is taken only when a pulse with no load in it ends
	logic pl_used_q;
	wire  pl_fall = !pl_s && pl_q;
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) pl_used_q <= 1'b0;
		else if (pl_rise || ls_rise) pl_used_q <= ls_rise && pl_s;
	end
	assign w_in.valid = on && pl_fall && !pl_used_q && is_wflash &&
		wr_en_q && !busy;
	assign w_in.word  = {word_idx, dhi_q2, dlo_q};
	assign w_out.ready = drain_q;
	ppp_fifo #(.WIDTH(22), .DEPTH(FIFO_DEPTH)) u_page (
		.clk_sys (clk_sys),
		.rst_n   (rst_n),
		.wr      (w_in),
		.rd      (w_out)
	);

	////////////////////////////////////////////////////////////////////////
	// operations
	wire start = on && wr_fall && !busy && wr_en_q;
	wire do_erase = start && cmd_q == CMD_ERASE;
	wire do_prog  = start && is_wflash;
	// fuse write with byte_sel_ext high lands in the extended byte
	wire set_ext  = start && cmd_q == CMD_WR_FUSE && a1_s && !pl_s;
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) dext_q <= '0;
		else if (set_ext) dext_q <= dlo_q;
	end
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			op_q         <= PPP_IDLE;
			opcnt_q      <= '0;
			drain_q      <= 1'b0;
			flash_we     <= 1'b0;
			flash_addr   <= '0;
			flash_wdata  <= '0;
			erase_flash  <= 1'b0;
			erase_eeprom <= 1'b0;
			clear_locks  <= 1'b0;
			ee_page_we   <= 1'b0;
		end else begin
			flash_we     <= 1'b0;
			erase_flash  <= 1'b0;
			erase_eeprom <= 1'b0;
			clear_locks  <= 1'b0;
			ee_page_we   <= 1'b0;
			opcnt_q      <= busy ? opcnt_q + 1'b1 : '0;
			unique case (op_q)
				PPP_IDLE: if (do_erase) begin
					op_q         <= PPP_ERASE;
					erase_flash  <= 1'b1;
					erase_eeprom <= eeprom_keep_fuse;
				end else if (do_prog) begin
					op_q    <= PPP_PROG;
					drain_q <= 1'b1;
				end
				PPP_ERASE: if (opcnt_q == 8'(ERASE_CYC - 1)) begin
					op_q        <= PPP_DONE;
					clear_locks <= 1'b1;
				end
				PPP_PROG: begin
					if (w_out.valid && drain_q) begin
						flash_we    <= cmd_q == CMD_WR_FLASH;
						ee_page_we  <= cmd_q == CMD_WR_EE;
						flash_addr  <= {page_idx, w_out.word[21:16]};
						flash_wdata <= w_out.word[15:0];
					end
					if (!w_out.valid) drain_q <= 1'b0;
					if (opcnt_q == 8'(PROG_CYC - 1)) op_q <= PPP_DONE;
				end
				PPP_DONE: begin
					op_q    <= PPP_IDLE;
					drain_q <= 1'b0;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// read path and status outputs
	wire is_read = cmd_q == CMD_RD_FLASH || cmd_q == CMD_RD_EE ||
		cmd_q == CMD_RD_SIG || cmd_q == CMD_RD_FUSE;
	wire [7:0] rd_byte = (cmd_q == CMD_RD_SIG) ? SIG_DEFAULT :
		(cmd_q == CMD_RD_FUSE && a1_s && !pl_s) ? dext_q :
		(cmd_q == CMD_RD_FUSE) ? {pl_s, a1_s, 6'h3F} :
		pl_s ? dhi_q2 ^ flash_rd_data : flash_rd_data;
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			data_out       <= '0;
			data_oe        <= 1'b0;
			ready_not_busy <= 1'b1;
			prog_active    <= 1'b0;
			cmd_out        <= '0;
		end else begin
			data_oe        <= on && !oe_s && is_read;
			data_out       <= rd_byte;
			ready_not_busy <= !(busy || do_erase || do_prog);
			prog_active    <= on;
			cmd_out        <= cmd_q;
		end
	end

	////////////////////////////////////////////////////////////////////////
	rdy_busy_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		do_erase |=> !ready_not_busy) else $error("busy not shown");
	oe_gate_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		data_oe |-> $past(!oe_s)) else $error("bus driven off-enable");
	busy_ignore_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		busy && ls_rise |=> $stable(cmd_q)) else $error("load while busy");
	entry_abort_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		mode_q == PPP_SETTLE && pattern != 4'h0 |=> mode_q == PPP_OFF)
		else $error("entry not aborted");
	nop_clear_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		load_ok && act == ACT_CMD && din_s == CMD_NOP |=> !wr_en_q)
		else $error("nop kept writes");
	// pulse is launched on the edge after the last count, so seen one later
	localparam int ERASE_LAT = ERASE_CYC + 1;
	erase_len_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		do_erase |-> ##ERASE_LAT clear_locks) else $error("erase length");
	cmd_keep_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		!load_ok |=> $stable(cmd_q) && $stable(alo_q)) else $error("cmd lost");
	latch_push_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		w_in.valid && w_in.ready |-> w_in.word[21:16] == alo_q[5:0])
		else $error("wrong word index");
endmodule

// ===== rtl/ppp_sync.sv
`timescale 1ns/100ps
module ppp_sync #(
	parameter int W = 14
) (
	input  wire logic         clk_sys,  // system clock
	input  wire logic         rst_n,    // async reset
	input  wire logic [W-1:0] d,        // pin levels
	output logic      [W-1:0] q         // synchronised levels
);
	logic [W-1:0] s1_q;
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			s1_q <= '0;
			q    <= '0;
		end else begin
			s1_q <= d;
			q    <= s1_q;
		end
	end
endmodule
